//--- rtl/fbs_status.sv
// status leds, station address, diagnostic log and redundancy of the slave
//
// The AXI4-Lite interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module fbs_status (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write address, data and response
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // station address selector and supply
    input wire logic [6:0] addr_selector,
    input wire logic power_good,
    // fieldbus and backplane activity, diagnostic events
    input wire logic fieldbus_activity,
    input wire logic backplane_faster,
    input wire logic diag_event,
    input wire logic [15:0] diag_code,
    // redundancy
    input wire logic partner_alive,
    // indicators
    output logic power_indicator,
    output logic error_indicator,
    output logic ready_indicator,
    output logic exchange_indicator,
    // station address and outputs
    output logic [6:0] station_address,
    output logic station_addr_valid,
    output logic outputs_enable,
    output logic self_alive,
    output logic flash_snapshot
);
    localparam int unsigned CNT_W_L = fbs_pkg::CNT_W;
    localparam logic [CNT_W_L-1:0] BL_MAX =
        CNT_W_L'(fbs_pkg::BLINK_HALF_CYC - 1);
    localparam logic [CNT_W_L-1:0] RS_MAX = CNT_W_L'(fbs_pkg::RESTART_CYC);

    typedef struct packed {
        logic awdone;
        logic wdone;
        logic [7:0] awaddr;
        logic [31:0] wdata;
        logic bvalid;
        logic [1:0] bresp;
        fbs_pkg::fbs_rd_t rd;
        logic [7:0] araddr;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [fbs_pkg::CTRL_W-1:0] ctrl;
        logic [5:0] modules;
        logic [5:0] analog;
        logic [7:0] in_bytes;
        logic [7:0] out_bytes;
        logic [fbs_pkg::LOG_AW-1:0] log_wr;
        logic [fbs_pkg::LOG_AW-1:0] log_idx;
        logic [31:0] tstamp;
        logic [CNT_W_L-1:0] blink_cnt;
        logic blink;
        logic [CNT_W_L-1:0] rst_cnt;
        logic addr_taken;
        logic [6:0] addr;
        logic snap_done;
        logic snap;
        logic partner_q;
        logic took_over;
        logic active;
        logic led_pw;
        logic led_er;
        logic led_rd;
        logic led_de;
    } fbs_state_t;

    fbs_state_t st_r;
    fbs_state_t st_nxt;
    logic [15:0] log_code_r [fbs_pkg::LOG_DEPTH];
    logic [31:0] log_time_r [fbs_pkg::LOG_DEPTH];
    logic wr_fire;
    logic lim_ok;

    // log storage, one entry per slot
    genvar g;
    for (g = 0; g < fbs_pkg::LOG_DEPTH; g++) begin : g_log
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                log_code_r[g] <= 16'h0000;
                log_time_r[g] <= 32'h0000_0000;
            end else if (diag_event &&
                         st_r.log_wr == fbs_pkg::LOG_AW'(g)) begin
                log_code_r[g] <= diag_code;
                log_time_r[g] <= st_r.tstamp;
            end
        end
    end

    assign wr_fire = st_r.awdone && st_r.wdone && !st_r.bvalid;

    always_comb begin
        st_nxt = st_r;
        lim_ok = 1'b1;
        st_nxt.tstamp = st_r.tstamp + 32'h0000_0001;
        if (diag_event) begin
            st_nxt.log_wr = st_r.log_wr + fbs_pkg::LOG_AW'(1);
        end
        // write channel: address and data in either order
        if (s_axi_awvalid && !st_r.awdone) begin
            st_nxt.awdone = 1'b1;
            st_nxt.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !st_r.wdone) begin
            st_nxt.wdone = 1'b1;
            st_nxt.wdata = s_axi_wdata;
        end
        st_nxt.ctrl[fbs_pkg::CTRL_RESTART] = 1'b0;
        if (wr_fire) begin
            st_nxt.bvalid = 1'b1;
            st_nxt.bresp = fbs_pkg::RESP_OKAY;
            case (st_r.awaddr)
                fbs_pkg::REG_CTRL: begin
                    st_nxt.ctrl = st_r.wdata[fbs_pkg::CTRL_W-1:0];
                end
                fbs_pkg::REG_IMAGE: begin
                    // limits checked; oversized config is refused
                    if (st_r.wdata[5:0] > fbs_pkg::MAX_MODULES ||
                        st_r.wdata[13:8] > fbs_pkg::MAX_ANALOG ||
                        st_r.wdata[13:8] > st_r.wdata[5:0] ||
                        st_r.wdata[23:16] > fbs_pkg::MAX_IMAGE_BYTES ||
                        st_r.wdata[31:24] > fbs_pkg::MAX_IMAGE_BYTES) begin
                        lim_ok = 1'b0;
                    end
                    if (lim_ok) begin
                        st_nxt.modules = st_r.wdata[5:0];
                        st_nxt.analog = st_r.wdata[13:8];
                        st_nxt.in_bytes = st_r.wdata[23:16];
                        st_nxt.out_bytes = st_r.wdata[31:24];
                    end else begin
                        st_nxt.bresp = fbs_pkg::RESP_SLVERR;
                    end
                end
                fbs_pkg::REG_LOG_IDX: begin
                    st_nxt.log_idx = st_r.wdata[fbs_pkg::LOG_AW-1:0];
                end
                default: begin
                    st_nxt.bresp = fbs_pkg::RESP_SLVERR;
                end
            endcase
        end
        if (st_r.bvalid && s_axi_bready) begin
            st_nxt.bvalid = 1'b0;
            st_nxt.awdone = 1'b0;
            st_nxt.wdone = 1'b0;
        end
        // read channel
        case (st_r.rd)
            fbs_pkg::FBS_RD_IDLE: begin
                if (s_axi_arvalid) begin
                    st_nxt.araddr = s_axi_araddr;
                    st_nxt.rd = fbs_pkg::FBS_RD_BUSY;
                end
            end
            fbs_pkg::FBS_RD_BUSY: begin
                st_nxt.rresp = fbs_pkg::RESP_OKAY;
                st_nxt.rd = fbs_pkg::FBS_RD_RESP;
                case (st_r.araddr)
                    fbs_pkg::REG_CTRL:
                        st_nxt.rdata = 32'(st_r.ctrl);
                    fbs_pkg::REG_STATUS:
                        st_nxt.rdata = {16'h0000, st_r.addr_taken,
                            st_r.active, st_r.partner_q, st_r.snap_done,
                            st_r.led_pw, st_r.led_er, st_r.led_rd,
                            st_r.led_de, 1'b0, st_r.addr};
                    fbs_pkg::REG_IMAGE:
                        st_nxt.rdata = {st_r.out_bytes, st_r.in_bytes,
                            2'h0, st_r.analog, 2'h0, st_r.modules};
                    fbs_pkg::REG_LOG_IDX:
                        st_nxt.rdata = {24'h00_0000, 4'h0, st_r.log_wr};
                    fbs_pkg::REG_LOG_DATA:
                        st_nxt.rdata = {16'h0000, log_code_r[st_r.log_idx]};
                    fbs_pkg::REG_LOG_TIME:
                        st_nxt.rdata = log_time_r[st_r.log_idx];
                    fbs_pkg::REG_TIME:
                        st_nxt.rdata = st_r.tstamp;
                    default: begin
                        st_nxt.rdata = 32'h0000_0000;
                        st_nxt.rresp = fbs_pkg::RESP_SLVERR;
                    end
                endcase
            end
            fbs_pkg::FBS_RD_RESP: begin
                if (s_axi_rready) begin
                    st_nxt.rd = fbs_pkg::FBS_RD_IDLE;
                end
            end
            default: st_nxt.rd = fbs_pkg::FBS_RD_IDLE;
        endcase
        // blink base, half period from the clock rate
        if (st_r.blink_cnt >= BL_MAX) begin
            st_nxt.blink_cnt = '0;
            st_nxt.blink = !st_r.blink;
        end else begin
            st_nxt.blink_cnt = st_r.blink_cnt + CNT_W_L'(1);
        end
        // restart pulse, started at reset release or by software
        if (st_r.ctrl[fbs_pkg::CTRL_RESTART]) begin
            st_nxt.rst_cnt = RS_MAX;
        end else if (st_r.rst_cnt != '0) begin
            st_nxt.rst_cnt = st_r.rst_cnt - CNT_W_L'(1);
        end
        // station address latched once after each reset release
        if (!st_r.addr_taken) begin
            st_nxt.addr_taken = 1'b1;
            st_nxt.addr = addr_selector;
        end else if (addr_selector == fbs_pkg::ADDR_SNAP &&
                     !st_r.snap_done) begin
            st_nxt.snap_done = 1'b1;
        end
        st_nxt.snap = st_r.addr_taken && !st_r.snap_done &&
            addr_selector == fbs_pkg::ADDR_SNAP;
        // redundancy: a silent partner hands the outputs to us
        st_nxt.partner_q = partner_alive;
        // activity from plain mode must not leak into redundant mode,
        // else both channels would drive the outputs at once
        if (!st_r.ctrl[fbs_pkg::CTRL_REDUNDANT]) begin
            st_nxt.active = 1'b1;
            st_nxt.took_over = 1'b0;
        end else if (!partner_alive) begin
            st_nxt.active = 1'b1;
            st_nxt.took_over = 1'b1;
        end else begin
            st_nxt.active = st_r.took_over;
        end
        // indicators
        st_nxt.led_pw = power_good;
        st_nxt.led_de = fieldbus_activity;
        if (st_r.ctrl[fbs_pkg::CTRL_INT_ERR]) begin
            st_nxt.led_er = 1'b1;
        end else if (st_r.ctrl[fbs_pkg::CTRL_INIT_ERR]) begin
            st_nxt.led_er = st_r.blink;
        end else if (st_r.ctrl[fbs_pkg::CTRL_CFG_ERR]) begin
            st_nxt.led_er = st_r.blink;
        end else begin
            st_nxt.led_er = st_r.rst_cnt != '0;
        end
        if (st_r.ctrl[fbs_pkg::CTRL_CFG_ERR]) begin
            if (st_r.ctrl[fbs_pkg::CTRL_CFG_INPHASE]) begin
                st_nxt.led_rd = st_r.blink;
            end else begin
                st_nxt.led_rd = !st_r.blink;
            end
        end else if (st_r.ctrl[fbs_pkg::CTRL_REDUNDANT]) begin
            st_nxt.led_rd = st_r.active;
        end else if (st_r.ctrl[fbs_pkg::CTRL_EXCHANGE]) begin
            st_nxt.led_rd = backplane_faster;
        end else if (st_r.ctrl[fbs_pkg::CTRL_SELFTEST_OK] &&
                     st_r.ctrl[fbs_pkg::CTRL_INIT_DONE]) begin
            st_nxt.led_rd = st_r.blink;
        end else begin
            st_nxt.led_rd = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_r <= '0;
            st_r.rd <= fbs_pkg::FBS_RD_IDLE;
            st_r.rst_cnt <= RS_MAX;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign s_axi_awready = !st_r.awdone;
    assign s_axi_wready = !st_r.wdone;
    assign s_axi_bvalid = st_r.bvalid;
    assign s_axi_bresp = st_r.bresp;
    assign s_axi_arready = st_r.rd == fbs_pkg::FBS_RD_IDLE;
    assign s_axi_rvalid = st_r.rd == fbs_pkg::FBS_RD_RESP;
    assign s_axi_rdata = st_r.rdata;
    assign s_axi_rresp = st_r.rresp;
    assign power_indicator = st_r.led_pw;
    assign error_indicator = st_r.led_er;
    assign ready_indicator = st_r.led_rd;
    assign exchange_indicator = st_r.led_de;
    assign station_address = st_r.addr;
    // address 0 and above 99 are not usable stations
    assign station_addr_valid = st_r.addr_taken &&
        st_r.addr >= fbs_pkg::ADDR_MIN &&
        st_r.addr <= fbs_pkg::ADDR_MAX;
    assign outputs_enable = st_r.active;
    assign self_alive = st_r.addr_taken && !st_r.ctrl[fbs_pkg::CTRL_INT_ERR];
    assign flash_snapshot = st_r.snap;
endmodule : fbs_status

//--- rtl/fbs_pkg.sv
// shared constants and types of the fieldbus slave status block
package fbs_pkg;
    localparam int unsigned CLK_HZ = 100_000_000;
    localparam int unsigned BLINK_HALF_MS = 250;
    localparam int unsigned RESTART_MS = 500;
    localparam int unsigned BLINK_HALF_CYC = CLK_HZ / 1000 * BLINK_HALF_MS;
    localparam int unsigned RESTART_CYC = CLK_HZ / 1000 * RESTART_MS;
    localparam int unsigned CNT_W = 32;
    localparam logic [5:0] MAX_MODULES = 6'h20;
    localparam logic [5:0] MAX_ANALOG = 6'h10;
    localparam logic [7:0] MAX_IMAGE_BYTES = 8'h98;
    localparam logic [6:0] ADDR_MIN = 7'h01;
    localparam logic [6:0] ADDR_MAX = 7'h63;
    localparam logic [6:0] ADDR_SNAP = 7'h00;
    localparam logic [5:0] LOG_DEPTH = 6'h10;
    localparam int unsigned LOG_AW = 4;
    // register byte addresses
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_IMAGE = 8'h08;
    localparam logic [7:0] REG_LOG_IDX = 8'h0c;
    localparam logic [7:0] REG_LOG_DATA = 8'h10;
    localparam logic [7:0] REG_LOG_TIME = 8'h14;
    localparam logic [7:0] REG_TIME = 8'h18;
    // ctrl fields
    localparam int unsigned CTRL_INT_ERR = 0;
    localparam int unsigned CTRL_INIT_ERR = 1;
    localparam int unsigned CTRL_CFG_ERR = 2;
    localparam int unsigned CTRL_CFG_INPHASE = 3;
    localparam int unsigned CTRL_SELFTEST_OK = 4;
    localparam int unsigned CTRL_INIT_DONE = 5;
    localparam int unsigned CTRL_EXCHANGE = 6;
    localparam int unsigned CTRL_REDUNDANT = 7;
    localparam int unsigned CTRL_RESTART = 8;
    localparam int unsigned CTRL_W = 9;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [2:0] {
        FBS_RD_IDLE = 3'h1,
        FBS_RD_BUSY = 3'h2,
        FBS_RD_RESP = 3'h4
    } fbs_rd_t;
endpackage : fbs_pkg

//--- tb/fbs_status_checker.sv
// concurrent checks on the ports of the fieldbus slave status block
`timescale 1ns/1ps
module fbs_status_checker (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // watched inputs
    input wire logic power_good,
    input wire logic fieldbus_activity,
    input wire logic [6:0] addr_selector,
    input wire logic s_axi_bready,
    input wire logic s_axi_rready,
    // watched outputs
    input wire logic power_indicator,
    input wire logic exchange_indicator,
    input wire logic error_indicator,
    input wire logic [6:0] station_address,
    input wire logic station_addr_valid,
    input wire logic flash_snapshot,
    input wire logic s_axi_bvalid,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_rvalid,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_arready
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    logic snap_seen_r;
    logic snap_seen_nxt;
    // one pulse per session, so remember it until the next reset
    always_comb snap_seen_nxt = snap_seen_r | flash_snapshot;
    always_ff @(posedge aclk) begin
        if (!aresetn)
            snap_seen_r <= 1'b0;
        else
            snap_seen_r <= snap_seen_nxt;
    end
    property p_pwr_follow;
        $past(aresetn) |-> power_indicator == $past(power_good);
    endproperty
    a_pwr_follow: assert property (p_pwr_follow)
        else $error("power indicator does not follow supply");
    property p_exch_follow;
        $past(aresetn) |-> exchange_indicator == $past(fieldbus_activity);
    endproperty
    a_exch_follow: assert property (p_exch_follow)
        else $error("exchange indicator does not follow activity");
    property p_restart_on;
        $rose(aresetn) |-> ##2 error_indicator;
    endproperty
    a_restart_on: assert property (p_restart_on)
        else $error("error indicator not lit after restart");
    property p_addr_latch;
        $rose(aresetn) |=> station_address == $past(addr_selector);
    endproperty
    a_addr_latch: assert property (p_addr_latch)
        else $error("station address not taken from selector");
    property p_addr_hold;
        $past(aresetn) && $past(aresetn, 2) |-> $stable(station_address);
    endproperty
    a_addr_hold: assert property (p_addr_hold)
        else $error("station address changed in session");
    property p_addr_range;
        station_addr_valid == (station_address >= fbs_pkg::ADDR_MIN &&
            station_address <= fbs_pkg::ADDR_MAX);
    endproperty
    a_addr_range: assert property (p_addr_range)
        else $error("address valid flag disagrees with range");
    property p_snap_once;
        flash_snapshot |-> !snap_seen_r;
    endproperty
    a_snap_once: assert property (p_snap_once)
        else $error("second flash snapshot in one session");
    property p_bresp_hold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_bresp_hold: assert property (p_bresp_hold)
        else $error("write response dropped before bready");
    property p_rdata_hold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_rdata_hold: assert property (p_rdata_hold)
        else $error("read data dropped before rready");
    property p_ar_refuse;
        s_axi_rvalid |-> !s_axi_arready;
    endproperty
    a_ar_refuse: assert property (p_ar_refuse)
        else $error("read address accepted while busy");
endmodule : fbs_status_checker
bind fbs_status fbs_status_checker u_chk (.aclk, .aresetn, .power_good,
    .fieldbus_activity, .addr_selector, .s_axi_bready, .s_axi_rready,
    .power_indicator, .exchange_indicator, .error_indicator,
    .station_address, .station_addr_valid, .flash_snapshot, .s_axi_bvalid,
    .s_axi_bresp, .s_axi_rvalid, .s_axi_rdata, .s_axi_arready);

//--- tb/fbs_partner.sv
// far-side model: partner channel and fieldbus master traffic
`timescale 1ns/1ps
module fbs_partner (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // scenario controls
    input wire logic alive_req,
    input wire logic traffic_req,
    // toward the slave
    output logic partner_alive,
    output logic fieldbus_activity
);
    typedef struct packed {logic alive; logic traffic;} fbs_far_t;
    fbs_far_t far_r;
    fbs_far_t far_nxt;
    always_comb begin
        far_nxt.alive = alive_req;
        far_nxt.traffic = traffic_req;
    end
    always_ff @(posedge aclk) begin
        if (!aresetn)
            far_r <= '0;
        else
            far_r <= far_nxt;
    end
    assign partner_alive = far_r.alive;
    assign fieldbus_activity = far_r.traffic;
endmodule : fbs_partner

//--- tb/fbs_status_tb_top.sv
// self-checking bench of the fieldbus slave status block
`timescale 1ns/1ps
module fbs_status_tb_top;
    typedef struct {bit w; logic [7:0] a; logic [31:0] d;
        logic [1:0] r; logic [31:0] q;} fbs_row_t;
    localparam logic [31:0] IMG = 32'h9898_1020;
    localparam logic [1:0] OK = fbs_pkg::RESP_OKAY;
    localparam logic [1:0] ER = fbs_pkg::RESP_SLVERR;
    localparam logic [7:0] IM = fbs_pkg::REG_IMAGE;
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd, t0;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
    logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
    logic s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [6:0] addr_selector, station_address;
    logic power_good, fieldbus_activity, backplane_faster, diag_event;
    logic [15:0] diag_code;
    logic partner_alive, power_indicator, error_indicator, ready_indicator;
    logic exchange_indicator, station_addr_valid, outputs_enable;
    logic self_alive, flash_snapshot, alive_req, traffic_req;
    int failures = 0;
    int n_compared = 0;
    int cyc = 0;
    int snaps = 0;
    // limits at the edges, beyond them, and a place nothing lives at
    fbs_row_t rows [11] = '{'{0, 8'h00, 0, OK, 0}, '{1, IM, IMG, OK, 0},
        '{0, IM, 0, OK, IMG}, '{1, IM, 32'h9898_1021, ER, 0},
        '{1, IM, 32'h9898_1120, ER, 0}, '{1, IM, 32'h9998_1020, ER, 0},
        '{1, IM, 32'h9899_1020, ER, 0}, '{1, IM, 32'h0000_0504, ER, 0},
        '{0, IM, 0, OK, IMG}, '{0, 8'h1c, 0, ER, 0}, '{1, 8'h1c, 0, ER, 0}};
    fbs_status uut (.*);
    fbs_partner u_far (.aclk, .aresetn, .alive_req, .traffic_req,
        .partner_alive, .fieldbus_activity);
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end
    task automatic summarize;
        $display("compared %0d mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : summarize
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (flash_snapshot === 1'b1)
            snaps <= snaps + 1;
        if (cyc == 6000) begin
            failures++;
            summarize();
        end
    end
    task automatic chk(input string nm, input logic [31:0] s, e);
        n_compared++;
        if (s !== e) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(posedge aclk);
    endtask : tick
    // response ready offered with the request and held until answered
    task automatic axi(input bit w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_araddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= w;
        s_axi_wvalid <= w;
        s_axi_arvalid <= !w;
        s_axi_bready <= w;
        s_axi_rready <= !w;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!(s_axi_bvalid && s_axi_bready) &&
            !(s_axi_rvalid && s_axi_rready) && n < 200);
        rsp = w ? s_axi_bresp : s_axi_rresp;
        rd = s_axi_rdata;
        s_axi_bready <= 1'b0;
        s_axi_rready <= 1'b0;
        if (n >= 200) failures++;
    endtask : axi
    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = '0;
        {s_axi_bready, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
        {s_axi_wdata, diag_event, diag_code, traffic_req} = '0;
        {backplane_faster, s_axi_wstrb} = 5'h1f;
        {power_good, alive_req, addr_selector} = {2'h3, 7'h2a};
        tick(10);
        aresetn <= 1'b1;
        tick(4);
        chk("er_led", 32'(error_indicator), 1);
        chk("addr", 32'(station_address), 32'h2a);
        chk("addr_ok", 32'(station_addr_valid), 1);
        chk("pw_led", 32'(power_indicator), 1);
        $display("test reset done");
        foreach (rows[i]) begin
            axi(rows[i].w, rows[i].a, rows[i].d);
            chk("resp", 32'(rsp), 32'(rows[i].r));
            if (!rows[i].w) chk("rdata", rd, rows[i].q);
        end
        $display("test registers done");
        addr_selector <= 7'h05;
        tick(5);
        addr_selector <= 7'h00;
        tick(5);
        addr_selector <= 7'h07;
        tick(5);
        addr_selector <= 7'h00;
        tick(5);
        chk("addr_kept", 32'(station_address), 32'h2a);
        chk("snaps", 32'(snaps), 1);
        $display("test selector done");
        traffic_req <= 1'b1;
        tick(4);
        chk("de_led", 32'(exchange_indicator), 1);
        axi(0, fbs_pkg::REG_STATUS, 0);
        chk("st_de", 32'(rd[8]), 1);
        traffic_req <= 1'b0;
        tick(4);
        chk("de_off", 32'(exchange_indicator), 0);
        axi(1, 8'h00, 32'h70);
        tick(3);
        chk("rd_fast", 32'(ready_indicator), 1);
        backplane_faster <= 1'b0;
        tick(3);
        chk("rd_slow", 32'(ready_indicator), 0);
        axi(1, 8'h00, 32'h74);
        tick(3);
        chk("alt", 32'(error_indicator ^ ready_indicator), 1);
        axi(1, 8'h00, 32'h7c);
        tick(3);
        chk("inph", 32'(error_indicator ^ ready_indicator), 0);
        axi(1, 8'h00, 32'h7d);
        tick(3);
        chk("int_err", 32'(error_indicator), 1);
        $display("test indicators done");
        diag_code <= 16'hbeef;
        diag_event <= 1'b1;
        tick(1);
        diag_event <= 1'b0;
        tick(2);
        axi(0, fbs_pkg::REG_LOG_IDX, 0);
        chk("wptr", 32'(rd[3:0]), 1);
        axi(1, fbs_pkg::REG_LOG_IDX, 0);
        axi(0, fbs_pkg::REG_LOG_DATA, 0);
        chk("code", 32'(rd[15:0]), 32'hbeef);
        axi(0, fbs_pkg::REG_LOG_TIME, 0);
        t0 = rd;
        axi(0, fbs_pkg::REG_TIME, 0);
        chk("stamp", 32'(t0 != 0 && t0 < rd), 1);
        $display("test log done");
        axi(1, 8'h00, 32'hf0);
        {traffic_req, backplane_faster} <= 2'h3;
        tick(4);
        chk("oe_pass", 32'(outputs_enable), 0);
        chk("rd_pass", 32'(ready_indicator), 0);
        chk("de_pass", 32'(exchange_indicator), 1);
        chk("alive", 32'(self_alive), 1);
        alive_req <= 1'b0;
        tick(4);
        chk("oe_take", 32'(outputs_enable), 1);
        chk("rd_act", 32'(ready_indicator), 1);
        alive_req <= 1'b1;
        tick(4);
        chk("oe_keep", 32'(outputs_enable), 1);
        $display("test redundancy done");
        aresetn <= 1'b0;
        addr_selector <= 7'h11;
        tick(3);
        chk("rst_oe", 32'(outputs_enable), 0);
        aresetn <= 1'b1;
        tick(4);
        chk("er_again", 32'(error_indicator), 1);
        chk("addr_new", 32'(station_address), 32'h11);
        $display("test second reset done");
        summarize();
    end
endmodule : fbs_status_tb_top
